/* rtl/srs_cfg.svh */
/*
  Offsets, field positions, reset values and widths of the status reporting block.
  Assumes it is included by the package and the design file by its bare name.
*/
`ifndef SRS_CFG_SVH
`define SRS_CFG_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SRS_OFF_OPER_EVT 12'h000
`define SRS_OFF_OPER_COND 12'h004
`define SRS_OFF_OPER_ENA 12'h008
`define SRS_OFF_OPER_PTR 12'h00C
`define SRS_OFF_OPER_NTR 12'h010
`define SRS_OFF_QUES_EVT 12'h020
`define SRS_OFF_QUES_COND 12'h024
`define SRS_OFF_QUES_ENA 12'h028
`define SRS_OFF_QUES_PTR 12'h02C
`define SRS_OFF_QUES_NTR 12'h030
`define SRS_OFF_CTRL 12'h040
`define SRS_OFF_ERRQ 12'h044
`define SRS_OFF_SUMM 12'h048
// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define SRS_CTRL_PRESET_BIT 0
`define SRS_CTRL_INSTR_RST_BIT 1
`define SRS_ERRQ_EMPTY_BIT 16
`define SRS_ERRQ_HAS_BIT 17
`define SRS_PTR_PRESET 16'hFFFF
`define SRS_NTR_PRESET 16'h0000
`define SRS_ENA_PRESET 16'h0000
`define SRS_ZERO16 16'h0000
`define SRS_NO_ERROR 16'h0000
`define SRS_RESP_OKAY 2'b00
`define SRS_RESP_SLVERR 2'b10
`endif

/* rtl/srs_pkg.sv */
/*
  Types shared by the status reporting block.
  Assumes srs_cfg.svh is on the include path.
*/
`include "srs_cfg.svh"
package srs_pkg;
    typedef logic [15:0] srs_word_t;
    typedef logic signed [15:0] srs_errnum_t;
    typedef logic [11:0] srs_addr_t;
endpackage : srs_pkg

/* rtl/srs_status.sv */
/*
  Status reporting block: operation and questionable groups, preset, error queue,
  reached over AXI4-Lite.
  Assumes one 100 MHz clock, synchronous active-low reset, live condition inputs
  synchronous to aclk, and a firmware-side error push port.
*/
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "srs_cfg.svh"
module srs_status #(
    parameter int ERRQ_DEPTH = 8,
    parameter int ERRQ_AW = 3
) (
    // clock, enable and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // live condition inputs
    input wire srs_pkg::srs_word_t oper_cond_in,
    input wire srs_pkg::srs_word_t ques_cond_in,
    // error push from the device side
    input wire logic err_push,
    input wire srs_pkg::srs_errnum_t err_num,
    // summary bits toward the status byte
    output logic oper_summary,
    output logic ques_summary,
    output logic errq_full,
    // axi4-lite write address and data
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import srs_pkg::*;

    // ----------------------------------------------------------------
    // write channel capture
    // ----------------------------------------------------------------
    srs_addr_t aw_q;
    logic aw_have_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    logic w_have_q;
    logic wr_fire;
    logic wr_ok;
    logic [15:0] wd;

    assign s_axi_awready = clk_en && !aw_have_q && !s_axi_bvalid; // frozen block takes nothing
    assign s_axi_wready = clk_en && !w_have_q && !s_axi_bvalid;
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    // low byte lanes only carry data; upper half of every writable register is reserved
    assign wd = {ws_q[1] ? w_q[15:8] : 8'h00, ws_q[0] ? w_q[7:0] : 8'h00};

    // address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 12'h000;
            w_q <= 32'h0000_0000;
            ws_q <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // which writable register the pending write hits
    logic wr_oena, wr_optr, wr_ontr, wr_qena, wr_qptr, wr_qntr, wr_ctrl;
    assign wr_oena = wr_fire && aw_q == `SRS_OFF_OPER_ENA;
    assign wr_optr = wr_fire && aw_q == `SRS_OFF_OPER_PTR;
    assign wr_ontr = wr_fire && aw_q == `SRS_OFF_OPER_NTR;
    assign wr_qena = wr_fire && aw_q == `SRS_OFF_QUES_ENA;
    assign wr_qptr = wr_fire && aw_q == `SRS_OFF_QUES_PTR;
    assign wr_qntr = wr_fire && aw_q == `SRS_OFF_QUES_NTR;
    assign wr_ctrl = wr_fire && aw_q == `SRS_OFF_CTRL;
    assign wr_ok = wr_oena || wr_optr || wr_ontr || wr_qena || wr_qptr || wr_qntr || wr_ctrl;

    // preset command is a self-clearing control bit
    logic preset;
    assign preset = wr_ctrl && ws_q[0] && w_q[`SRS_CTRL_PRESET_BIT];
    // instrument reset bit is accepted and changes no status part

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SRS_RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `SRS_RESP_OKAY : `SRS_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // read decode
    // ----------------------------------------------------------------
    logic rd_fire, rd_oevt, rd_qevt, rd_errq;
    assign s_axi_arready = clk_en && !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_oevt = rd_fire && s_axi_araddr == `SRS_OFF_OPER_EVT;
    assign rd_qevt = rd_fire && s_axi_araddr == `SRS_OFF_QUES_EVT;
    assign rd_errq = rd_fire && s_axi_araddr == `SRS_OFF_ERRQ;

    // ----------------------------------------------------------------
    // the two status groups
    // ----------------------------------------------------------------
    srs_word_t cond_in [2];
    srs_word_t cond_q [2];
    srs_word_t ptr_q [2];
    srs_word_t ntr_q [2];
    srs_word_t ena_q [2];
    srs_word_t evt_q [2];
    logic sum_q [2];
    logic wr_ena [2];
    logic wr_ptr [2];
    logic wr_ntr [2];
    logic rd_evt [2];
    assign cond_in = '{oper_cond_in, ques_cond_in};
    assign wr_ena = '{wr_oena, wr_qena};
    assign wr_ptr = '{wr_optr, wr_qptr};
    assign wr_ntr = '{wr_ontr, wr_qntr};
    assign rd_evt = '{rd_oevt, rd_qevt};

    for (genvar g = 0; g < 2; g++) begin : g_grp
        srs_word_t edges;
        // rising edges pass the positive filter, falling ones the negative
        assign edges = (cond_in[g] & ~cond_q[g] & ptr_q[g])
                     | (~cond_in[g] & cond_q[g] & ntr_q[g]);

        // previous condition, kept only for edge detection
        always_ff @(posedge aclk) begin
            if (!aresetn) cond_q[g] <= `SRS_ZERO16;
            else if (clk_en) cond_q[g] <= cond_in[g];
        end

        // filters and mask: preset overrides a write in the same cycle
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ptr_q[g] <= `SRS_PTR_PRESET;
                ntr_q[g] <= `SRS_NTR_PRESET;
                ena_q[g] <= `SRS_ENA_PRESET;
            end else if (clk_en) begin
                if (preset) begin
                    ptr_q[g] <= `SRS_PTR_PRESET;
                    ntr_q[g] <= `SRS_NTR_PRESET;
                    ena_q[g] <= `SRS_ENA_PRESET;
                end else begin
                    if (wr_ena[g]) ena_q[g] <= wd;
                    if (wr_ptr[g]) ptr_q[g] <= wd;
                    if (wr_ntr[g]) ntr_q[g] <= wd;
                end
            end
        end

        // sticky events; a new edge in the clearing cycle survives the read
        always_ff @(posedge aclk) begin
            if (!aresetn) evt_q[g] <= `SRS_ZERO16;
            else if (clk_en) begin
                if (rd_evt[g]) evt_q[g] <= edges;
                else evt_q[g] <= evt_q[g] | edges;
            end
        end

        // summary registered, one cycle behind event or mask
        always_ff @(posedge aclk) begin
            if (!aresetn) sum_q[g] <= 1'b0;
            else if (clk_en) sum_q[g] <= |(evt_q[g] & ena_q[g]);
        end
    end
    assign oper_summary = sum_q[0];
    assign ques_summary = sum_q[1];

    // ----------------------------------------------------------------
    // error queue
    // ----------------------------------------------------------------
    srs_errnum_t errq_mem [ERRQ_DEPTH];
    logic [ERRQ_AW-1:0] wp_q, rp_q;
    logic [ERRQ_AW:0] cnt_q;
    logic pop, push;
    assign pop = rd_errq && cnt_q != '0;
    // a full queue drops new errors rather than overwrite the oldest
    assign push = err_push && !errq_full;
    assign errq_full = cnt_q == (ERRQ_AW+1)'(ERRQ_DEPTH);

    // fifo pointers and storage, oldest first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (clk_en) begin
            if (push) wp_q <= (wp_q == ERRQ_AW'(ERRQ_DEPTH-1)) ? '0 : wp_q + 1'b1;
            if (pop) rp_q <= (rp_q == ERRQ_AW'(ERRQ_DEPTH-1)) ? '0 : rp_q + 1'b1;
            if (push && !pop) cnt_q <= cnt_q + 1'b1;
            else if (pop && !push) cnt_q <= cnt_q - 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (clk_en && push) errq_mem[wp_q] <= err_num;
    end
    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [31:0] rd_d;
    logic rd_bad;
    always_comb begin
        rd_d = 32'h0000_0000;
        rd_bad = 1'b0;
        case (s_axi_araddr)
            `SRS_OFF_OPER_EVT: rd_d[15:0] = evt_q[0];
            `SRS_OFF_OPER_COND: rd_d[15:0] = oper_cond_in;
            `SRS_OFF_OPER_ENA: rd_d[15:0] = ena_q[0];
            `SRS_OFF_OPER_PTR: rd_d[15:0] = ptr_q[0];
            `SRS_OFF_OPER_NTR: rd_d[15:0] = ntr_q[0];
            `SRS_OFF_QUES_EVT: rd_d[15:0] = evt_q[1];
            `SRS_OFF_QUES_COND: rd_d[15:0] = ques_cond_in;
            `SRS_OFF_QUES_ENA: rd_d[15:0] = ena_q[1];
            `SRS_OFF_QUES_PTR: rd_d[15:0] = ptr_q[1];
            `SRS_OFF_QUES_NTR: rd_d[15:0] = ntr_q[1];
            `SRS_OFF_CTRL: rd_d = 32'h0000_0000;
            `SRS_OFF_SUMM: rd_d[1:0] = {sum_q[1], sum_q[0]};
            `SRS_OFF_ERRQ: begin
                if (cnt_q == '0) begin
                    rd_d[15:0] = `SRS_NO_ERROR;
                    rd_d[`SRS_ERRQ_EMPTY_BIT] = 1'b1;
                end else begin
                    rd_d[15:0] = errq_mem[rp_q];
                    rd_d[`SRS_ERRQ_HAS_BIT] = cnt_q > (ERRQ_AW+1)'(1);
                end
            end
            default: rd_bad = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SRS_RESP_OKAY;
        end else if (clk_en) begin
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_d;
                s_axi_rresp <= rd_bad ? `SRS_RESP_SLVERR : `SRS_RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_preset;
        preset && clk_en;
    endsequence
    a_preset_ptr: assert property (@(posedge aclk) disable iff (!aresetn)
        s_preset |=> ptr_q[0] == `SRS_PTR_PRESET && ptr_q[1] == `SRS_PTR_PRESET)
        else $error("positive filters not all ones after preset");
    a_preset_ntr: assert property (@(posedge aclk) disable iff (!aresetn)
        s_preset |=> ntr_q[0] == `SRS_NTR_PRESET && ntr_q[1] == `SRS_NTR_PRESET)
        else $error("negative filters not cleared after preset");
    a_preset_ena: assert property (@(posedge aclk) disable iff (!aresetn)
        s_preset |=> ena_q[0] == `SRS_ENA_PRESET && ena_q[1] == `SRS_ENA_PRESET)
        else $error("enable masks not cleared after preset");
    a_evt_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && rd_oevt |=> (evt_q[0] & ~$past(g_grp[0].edges)) == 16'h0000)
        else $error("event part not cleared by read");
    a_evt_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && !rd_oevt |=> (evt_q[0] & $past(evt_q[0])) == $past(evt_q[0]))
        else $error("event bit lost without read");
    a_rise_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && (oper_cond_in & ~cond_q[0] & ptr_q[0]) != 16'h0000
        |=> (evt_q[0] & $past(oper_cond_in & ~cond_q[0] & ptr_q[0])) != 16'h0000)
        else $error("rising edge not latched");
    a_fall_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && (~ques_cond_in & cond_q[1] & ntr_q[1]) != 16'h0000
        |=> (evt_q[1] & $past(~ques_cond_in & cond_q[1] & ntr_q[1])) != 16'h0000)
        else $error("falling edge not latched");
    a_summary_or: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en |=> oper_summary == |($past(evt_q[0]) & $past(ena_q[0])))
        else $error("operation summary mismatch");
    a_empty_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && rd_errq && cnt_q == '0 |=> s_axi_rdata[15:0] == 16'h0000
        && s_axi_rdata[`SRS_ERRQ_EMPTY_BIT])
        else $error("empty queue read not no-error");
    a_cond_live: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && rd_fire && s_axi_araddr == `SRS_OFF_OPER_COND
        |=> s_axi_rdata[15:0] == $past(oper_cond_in) && evt_q[0] == ($past(evt_q[0]) | $past(g_grp[0].edges)))
        else $error("condition read wrong or disturbed events");
endmodule : srs_status
`default_nettype wire

/* verification/srs_ctl_model.sv */
/*
  Controller model: an AXI4-Lite master that runs one write or one read at a time.
  Assumes the bench calls wr and rd by hierarchical name, one call at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module srs_ctl_model (
    // clock
    input wire logic aclk,
    // write channels
    output logic [11:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // read channels
    output logic [11:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // idle bus before the first request
    initial begin
        s_axi_awaddr = 12'h000;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 12'h000;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end
    // a slow controller waits 0..2 cycles before it takes the answer
    task automatic answer(input bit is_rd);
        repeat ($urandom_range(2, 0)) @(posedge aclk);
        if (is_rd) s_axi_rready <= 1'b1;
        else s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!(is_rd ? s_axi_rvalid : s_axi_bvalid));
        s_axi_rready <= 1'b0;
        s_axi_bready <= 1'b0;
    endtask : answer
    // address and data go out together; each is released once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        bit aw_p;
        bit w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge aclk);
            if (aw_p && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_p && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                w_p = 1'b0;
            end
        end
        answer(1'b0);
    endtask : wr
    // read address held until taken, then the data beat is awaited
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        answer(1'b1);
    endtask : rd
endmodule : srs_ctl_model
`default_nettype wire

/* verification/srs_status_test.sv */
/*
  Self-checking bench for the status reporting block.
  Assumes the rtl files are compiled first and srs_ctl_model drives the bus.
*/
`timescale 1ns/1ps
`default_nettype none
`include "srs_cfg.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h, expected %h", $time, (g), (e)); end end
module srs_status_test;
    import srs_pkg::*;
    localparam int DEPTH = 8;
    int checked = 0;
    int mismatches = 0;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic clk_en = 1'b1;
    srs_word_t oper_cond = 16'h0000;
    srs_word_t ques_cond = 16'h0000;
    logic err_push = 1'b0;
    srs_errnum_t err_num = 16'h0000;
    logic oper_summary, ques_summary, errq_full;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [33:0] exp_r[$];
    logic [1:0] exp_b[$];
    logic [33:0] exp_rv;
    logic [1:0] exp_bv;
    srs_errnum_t q[$];
    srs_errnum_t e;
    srs_addr_t b;
    srs_word_t v;
    always #5 aclk = ~aclk;
    srs_status #(.ERRQ_DEPTH(DEPTH), .ERRQ_AW(3)) dut (.aclk, .aresetn, .clk_en,
        .oper_cond_in(oper_cond), .ques_cond_in(ques_cond), .err_push, .err_num,
        .oper_summary, .ques_summary, .errq_full, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    srs_ctl_model m (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
    // answers are compared in arrival order; each note is popped once, as the macro
    // would otherwise pop a second note while printing a mismatch
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            exp_rv = exp_r.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, exp_rv)
        end
        if (s_axi_bvalid && s_axi_bready) begin
            exp_bv = exp_b.pop_front();
            `CHK(s_axi_bresp, exp_bv)
        end
    end
    function automatic logic [33:0] okw(input srs_word_t x);
        return {`SRS_RESP_OKAY, 16'h0000, x};
    endfunction : okw
    task automatic rx(input logic [11:0] a, input logic [33:0] x);
        exp_r.push_back(x);
        m.rd(a);
    endtask : rx
    task automatic wx(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] r);
        exp_b.push_back(r);
        m.wr(a, d, s);
    endtask : wx
    // one extra edge lets the detector see the change before any read
    task automatic setc(input int g, input srs_word_t x);
        @(posedge aclk);
        if (g == 0) oper_cond <= x;
        else ques_cond <= x;
        @(posedge aclk);
    endtask : setc
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    // whole run needs about 350 cycles; this limit only cuts a hang
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        summarize();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hf0562d96));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int g = 0; g < 2; g++) begin
            b = 12'(g * 32);
            rx(b + `SRS_OFF_OPER_PTR, okw(16'hffff));
            rx(b + `SRS_OFF_OPER_NTR, okw(16'h0000));
            rx(b + `SRS_OFF_OPER_ENA, okw(16'h0000));
            rx(b + `SRS_OFF_OPER_EVT, okw(16'h0000));
        end
        $display("test reset values done");
        for (int g = 0; g < 2; g++) begin
            b = 12'(g * 32);
            v = 16'($urandom) | 16'h0001;
            setc(g, v);
            rx(b + `SRS_OFF_OPER_COND, okw(v));
            rx(b + `SRS_OFF_OPER_COND, okw(v));
            setc(g, 16'h0000);
            rx(b + `SRS_OFF_OPER_EVT, okw(v));
            rx(b + `SRS_OFF_OPER_EVT, okw(16'h0000));
            wx(b + `SRS_OFF_OPER_PTR, 32'h0000_0000, 4'hf, `SRS_RESP_OKAY);
            wx(b + `SRS_OFF_OPER_NTR, 32'h0000_ffff, 4'hf, `SRS_RESP_OKAY);
            setc(g, v);
            rx(b + `SRS_OFF_OPER_EVT, okw(16'h0000));
            setc(g, 16'h0000);
            rx(b + `SRS_OFF_OPER_EVT, okw(v));
        end
        $display("test transitions done");
        for (int g = 0; g < 2; g++) begin
            b = 12'(g * 32);
            setc(g, 16'h0004);
            setc(g, 16'h0000);
            wx(b + `SRS_OFF_OPER_ENA, 32'h0000_fffb, 4'hf, `SRS_RESP_OKAY);
            rx(`SRS_OFF_SUMM, okw(16'h0000));
            wx(b + `SRS_OFF_OPER_ENA, 32'h0000_0004, 4'hf, `SRS_RESP_OKAY);
            rx(`SRS_OFF_SUMM, okw(16'(g + 1)));
            `CHK((g == 0) ? oper_summary : ques_summary, 1'b1)
            rx(b + `SRS_OFF_OPER_EVT, okw(16'h0004));
            rx(`SRS_OFF_SUMM, okw(16'h0000));
        end
        wx(`SRS_OFF_QUES_ENA, 32'h0000_abcd, 4'b0001, `SRS_RESP_OKAY);
        rx(`SRS_OFF_QUES_ENA, okw(16'h00cd));
        wx(`SRS_OFF_QUES_ENA, 32'h0001_ffff, 4'hf, `SRS_RESP_OKAY);
        rx(`SRS_OFF_QUES_ENA, okw(16'hffff));
        $display("test summary done");
        wx(`SRS_OFF_CTRL, 32'h0000_0002, 4'hf, `SRS_RESP_OKAY);
        rx(`SRS_OFF_OPER_PTR, okw(16'h0000));
        rx(`SRS_OFF_QUES_ENA, okw(16'hffff));
        wx(`SRS_OFF_CTRL, 32'h0000_0001, 4'hf, `SRS_RESP_OKAY);
        for (int g = 0; g < 2; g++) begin
            b = 12'(g * 32);
            rx(b + `SRS_OFF_OPER_PTR, okw(16'hffff));
            rx(b + `SRS_OFF_OPER_NTR, okw(16'h0000));
            rx(b + `SRS_OFF_OPER_ENA, okw(16'h0000));
        end
        $display("test preset done");
        rx(`SRS_OFF_ERRQ, {`SRS_RESP_OKAY, 32'h0001_0000});
        // one push beyond the depth must be dropped
        for (int i = 0; i <= DEPTH; i++) begin
            e = 16'($urandom_range(500, 1));
            if (i % 2 == 1) e = -e;
            q.push_back(e);
            @(posedge aclk);
            err_push <= 1'b1;
            err_num <= e;
        end
        @(posedge aclk);
        err_push <= 1'b0;
        @(posedge aclk);
        `CHK(errq_full, 1'b1)
        for (int i = 0; i < DEPTH; i++) begin
            rx(`SRS_OFF_ERRQ, {`SRS_RESP_OKAY, 14'h0000, 1'(i < DEPTH - 1), 1'b0, q[i]});
        end
        rx(`SRS_OFF_ERRQ, {`SRS_RESP_OKAY, 32'h0001_0000});
        $display("test error queue done");
        // a frozen block must miss both a condition pulse and an error push
        @(posedge aclk);
        clk_en <= 1'b0;
        oper_cond <= 16'h00f0;
        err_push <= 1'b1;
        err_num <= 16'($urandom_range(500, 1));
        repeat (3) @(posedge aclk);
        oper_cond <= 16'h0000;
        err_push <= 1'b0;
        @(posedge aclk);
        clk_en <= 1'b1;
        rx(`SRS_OFF_OPER_EVT, okw(16'h0000));
        rx(`SRS_OFF_ERRQ, {`SRS_RESP_OKAY, 32'h0001_0000});
        $display("test clock enable done");
        rx(12'h0fc, {`SRS_RESP_SLVERR, 32'h0000_0000});
        wx(12'h0fc, 32'h0000_1234, 4'hf, `SRS_RESP_SLVERR);
        wx(`SRS_OFF_OPER_COND, 32'h0000_ffff, 4'hf, `SRS_RESP_SLVERR);
        rx(`SRS_OFF_OPER_COND, okw(16'h0000));
        $display("test refused accesses done");
        @(posedge aclk);
        `CHK(exp_r.size() + exp_b.size(), 0)
        summarize();
    end
endmodule : srs_status_test
`default_nettype wire
